// >>> design/sgcp_map.svh
// constants for the serial gain control port
`ifndef SGCP_MAP_SVH
`define SGCP_MAP_SVH

// gain word and code widths
`define SGCP_WORD_W 8
`define SGCP_CODE_W 3

// gain codes: minimum is the power-up code
`define SGCP_CODE_MIN 3'h0
`define SGCP_CODE_MAX 3'h7
`define SGCP_WORD_MAX 8'h07

// gain in dB at each end and per step
`define SGCP_DB_MIN 8'shf2
`define SGCP_DB_MAX 8'sh1c
`define SGCP_DB_STEP 8'sh06

// reset values
`define SGCP_RST_CODE 3'h0
`define SGCP_RST_WORD 8'h00

`endif

// >>> design/sgcp_pkg.sv
// types for the serial gain control port
package sgcp_pkg;

  // applied gain state
  typedef struct packed {
    logic on;
    logic [2:0] code;
    logic signed [7:0] db;
  } sgcp_gain_t;

  // pin levels after synchronising
  typedef struct packed {
    logic commit_en;
    logic power_on;
  } sgcp_pins_t;

  typedef enum logic [1:0] {
    SGCP_ST_OFF = 2'b00,
    SGCP_ST_LOAD = 2'b01,
    SGCP_ST_HOLD = 2'b10
  } sgcp_state_t;

endpackage : sgcp_pkg

// >>> design/sgcp_port.sv
// serial gain control port: shift register, commit and power control
//
// Overview of operation
// [R1] the gain word is 8 bits, sent and placed msb first.
// [R2] a bit is caught in the master on the serial clock rise, passed to the slave on its fall.
// [R3] the controller has each data bit valid by the clock edge that samples it.
// [R4] a rise of commit enable copies the word to the gain and stops shifting.
// [R5] a fall of commit enable freezes the applied gain and reopens the shift register.
// [R6] power select low turns the amplifier off; high turns it on at the minimum code.
// [R7] the applied code selects a gain from -14 dB to 28 dB in 6 dB steps.
// [R8] the low bits of the word index the step; a word above the top step clamps to it.
`include "sgcp_map.svh"

module sgcp_port (
  // system clock and control
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // serial link pins
  input wire logic SCLK_I,
  input wire logic SERIAL_GAIN_IN_I,
  input wire logic GAIN_COMMIT_ENABLE_I,
  input wire logic POWER_ON_SELECT_I,
  // applied gain
  output logic AMP_ON_O,
  output logic [2:0] GAIN_CODE_O,
  output logic signed [7:0] GAIN_DB_O,
  // status
  output logic GAIN_UPDATE_O,
  output logic SHIFT_OPEN_O
);

  // step index from a word, clamped to the top step
  function automatic logic [2:0] code_of(input logic [7:0] w);
    logic [2:0] c;
    c = `SGCP_CODE_MAX;
    if (w <= `SGCP_WORD_MAX) begin
      c = w[2:0];
    end
    return c;
  endfunction

  // gain in dB of a step index
  function automatic logic signed [7:0] db_of(input logic [2:0] c);
    logic signed [7:0] r;
    r = `SGCP_DB_MIN + $signed({5'h00, c}) * `SGCP_DB_STEP;
    return r;
  endfunction

  // full gain record for a code
  function automatic sgcp_pkg::sgcp_gain_t gain_of(
    input logic on,
    input logic [2:0] c
  );
    sgcp_pkg::sgcp_gain_t g;
    g.on = on;
    g.code = c;
    g.db = db_of(c);
    return g;
  endfunction

  // ---- serial clock domain

  logic [7:0] link_word;

  sgcp_shift u_shift (
    .sclk_i(SCLK_I),
    .din_i(SERIAL_GAIN_IN_I),
    .en_i(GAIN_COMMIT_ENABLE_I),
    .word_o(link_word)
  );

  // ---- crossing into the system domain

  sgcp_pkg::sgcp_pins_t pins_raw;
  sgcp_pkg::sgcp_pins_t pins_s;
  logic [7:0] word_s;

  assign pins_raw.commit_en = GAIN_COMMIT_ENABLE_I;
  assign pins_raw.power_on = POWER_ON_SELECT_I;

  sgcp_sync #(
    .W(2)
  ) u_sync_pins (
    .clk_i(CLK_I),
    .ce_i(CE_I),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // the word is quiet while enable is high, so a plain two-flop copy
  // is coherent by the time the enable edge has been seen
  sgcp_sync #(
    .W(8)
  ) u_sync_word (
    .clk_i(CLK_I),
    .ce_i(CE_I),
    .d_i(link_word),
    .q_o(word_s)
  );

  // ---- edge detection on the synchronised enable

  logic en_prev_q;
  logic en_prev_d;
  logic en_rise;
  logic en_fall;

  always_comb begin
    en_prev_d = CE_I ? pins_s.commit_en : en_prev_q;
    en_rise = pins_s.commit_en & ~en_prev_q;
    en_fall = ~pins_s.commit_en & en_prev_q;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_prev_d;
    end
  end

  // ---- power and commit state

  sgcp_pkg::sgcp_state_t st_q;
  sgcp_pkg::sgcp_state_t st_d;
  sgcp_pkg::sgcp_gain_t gain_q;
  sgcp_pkg::sgcp_gain_t gain_d;
  logic pend_q;
  logic pend_d;
  logic upd_q;
  logic upd_d;
  logic open_q;
  logic open_d;

  always_comb begin
    st_d = st_q;
    gain_d = gain_q;
    pend_d = 1'b0;
    upd_d = 1'b0;
    open_d = ~pins_s.commit_en;
    case (st_q)
      sgcp_pkg::SGCP_ST_OFF: begin
        if (pins_s.power_on) begin
          // power-up always starts from the minimum code
          gain_d = gain_of(1'b1, `SGCP_CODE_MIN); // [R6]
          st_d = pins_s.commit_en ? sgcp_pkg::SGCP_ST_HOLD : sgcp_pkg::SGCP_ST_LOAD;
        end
      end
      sgcp_pkg::SGCP_ST_LOAD: begin
        if (!pins_s.power_on) begin
          gain_d.on = 1'b0; // [R6]
          st_d = sgcp_pkg::SGCP_ST_OFF;
        end else if (en_rise) begin
          // one cycle of slack lets the word copy settle
          pend_d = 1'b1; // [R4]
          st_d = sgcp_pkg::SGCP_ST_HOLD;
        end
      end
      sgcp_pkg::SGCP_ST_HOLD: begin
        if (!pins_s.power_on) begin
          gain_d.on = 1'b0; // [R6]
          st_d = sgcp_pkg::SGCP_ST_OFF;
        end else if (pend_q) begin
          gain_d = gain_of(1'b1, code_of(word_s)); // [R4] [R7] [R8]
          upd_d = 1'b1;
        end else if (en_fall) begin
          // gain stays frozen while a new word loads
          st_d = sgcp_pkg::SGCP_ST_LOAD; // [R5]
        end
      end
      default: begin
        gain_d = gain_of(1'b0, `SGCP_RST_CODE);
        st_d = sgcp_pkg::SGCP_ST_OFF;
      end
    endcase
    if (!CE_I) begin
      st_d = st_q;
      gain_d = gain_q;
      pend_d = pend_q;
      upd_d = upd_q;
      open_d = open_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_q <= sgcp_pkg::SGCP_ST_OFF;
      gain_q <= gain_of(1'b0, `SGCP_RST_CODE);
      pend_q <= 1'b0;
      upd_q <= 1'b0;
      open_q <= 1'b0;
    end else begin
      st_q <= st_d;
      gain_q <= gain_d;
      pend_q <= pend_d;
      upd_q <= upd_d;
      open_q <= open_d;
    end
  end

  // ---- outputs, all straight from flops

  assign AMP_ON_O = gain_q.on;
  assign GAIN_CODE_O = gain_q.code;
  assign GAIN_DB_O = gain_q.db;
  assign GAIN_UPDATE_O = upd_q;
  assign SHIFT_OPEN_O = open_q;

  // ---- checks

  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (RST_I);

  commit_arm_a: assert property ( // [R4]
    st_q == sgcp_pkg::SGCP_ST_LOAD && pins_s.power_on && en_rise && CE_I
    |=> pend_q && st_q == sgcp_pkg::SGCP_ST_HOLD)
    else $error("enable rise did not arm a commit");

  commit_apply_a: assert property ( // [R4]
    pend_q && st_q == sgcp_pkg::SGCP_ST_HOLD && pins_s.power_on && CE_I
    |=> GAIN_UPDATE_O && GAIN_CODE_O == code_of($past(word_s)))
    else $error("committed code does not match the shifted word");

  gain_freeze_a: assert property ( // [R5]
    st_q == sgcp_pkg::SGCP_ST_LOAD |=> $stable(GAIN_CODE_O))
    else $error("gain changed while a word was loading");

  power_off_a: assert property ( // [R6]
    !pins_s.power_on && CE_I |=> !AMP_ON_O)
    else $error("amplifier on while power select low");

  power_min_a: assert property ( // [R6]
    st_q == sgcp_pkg::SGCP_ST_OFF && pins_s.power_on && CE_I
    |=> AMP_ON_O && GAIN_CODE_O == `SGCP_CODE_MIN)
    else $error("power-up did not start at minimum code");

  db_map_a: assert property ( // [R7]
    GAIN_DB_O == db_of(GAIN_CODE_O)
    && GAIN_DB_O >= `SGCP_DB_MIN && GAIN_DB_O <= `SGCP_DB_MAX)
    else $error("gain in dB does not match code");

  word_clamp_a: assert property ( // [R8]
    pend_q && st_q == sgcp_pkg::SGCP_ST_HOLD && pins_s.power_on && CE_I
    && word_s > `SGCP_WORD_MAX |=> GAIN_CODE_O == `SGCP_CODE_MAX)
    else $error("oversize word not clamped to top step");

  // a commit shows as a single pulse, and only after the arm cycle
  update_pulse_a: assert property ( // [R4]
    GAIN_UPDATE_O && CE_I |=> !GAIN_UPDATE_O)
    else $error("update pulse longer than one cycle");

  update_cause_a: assert property ( // [R4]
    $rose(GAIN_UPDATE_O) |-> $past(pend_q))
    else $error("update pulse without an armed commit");

  arm_in_hold_a: assert property ( // [R4]
    pend_q |-> st_q == sgcp_pkg::SGCP_ST_HOLD)
    else $error("commit armed outside the hold state");

  hold_stays_a: assert property ( // [R4]
    st_q == sgcp_pkg::SGCP_ST_HOLD && !pend_q && !en_fall && pins_s.power_on
    |=> st_q == sgcp_pkg::SGCP_ST_HOLD && $stable(GAIN_CODE_O))
    else $error("held gain moved without an enable fall");

  reopen_load_a: assert property ( // [R5]
    st_q == sgcp_pkg::SGCP_ST_HOLD && !pend_q && en_fall && pins_s.power_on && CE_I
    |=> st_q == sgcp_pkg::SGCP_ST_LOAD && $stable(GAIN_CODE_O))
    else $error("enable fall did not reopen loading with the gain held");

  shift_open_a: assert property ( // [R4] [R5]
    CE_I |=> SHIFT_OPEN_O == !$past(pins_s.commit_en))
    else $error("shift open status does not follow the enable");

  // clock enable low must freeze the whole system-clock side
  ce_hold_a: assert property ( // [R5]
    !CE_I |=> $stable(GAIN_CODE_O) && $stable(AMP_ON_O) && $stable(SHIFT_OPEN_O))
    else $error("state moved while clock enable was low");

  down_keep_a: assert property ( // [R6]
    st_q != sgcp_pkg::SGCP_ST_OFF && !pins_s.power_on && CE_I
    |=> st_q == sgcp_pkg::SGCP_ST_OFF && $stable(GAIN_CODE_O))
    else $error("power-down did not stop the amplifier cleanly");

  off_no_update_a: assert property ( // [R6]
    st_q == sgcp_pkg::SGCP_ST_OFF |=> !GAIN_UPDATE_O)
    else $error("gain update while powered down");

  commit_seen_c: cover property (en_rise ##1 pend_q ##1 GAIN_UPDATE_O);

  power_up_c: cover property (st_q == sgcp_pkg::SGCP_ST_OFF ##1 AMP_ON_O);

  clamp_seen_c: cover property (GAIN_UPDATE_O && GAIN_CODE_O == `SGCP_CODE_MAX);

  reload_c: cover property (GAIN_UPDATE_O ##[1:50] SHIFT_OPEN_O);

  power_down_c: cover property (AMP_ON_O ##1 !AMP_ON_O);

endmodule // sgcp_port

// >>> design/sgcp_shift.sv
// master-slave serial shift register, runs on the serial clock
`include "sgcp_map.svh"

module sgcp_shift (
  // serial link
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic en_i,
  // word toward the system domain
  output logic [7:0] word_o
);

  logic master_q;
  logic master_d;
  logic open_q;
  logic open_d;
  logic [7:0] slave_q;
  logic [7:0] slave_d;

  // master stage: bit and shift permission taken on the rising edge
  always_comb begin
    master_d = en_i ? master_q : din_i; // [R2]
    open_d = ~en_i; // [R4]
  end

  always_ff @(posedge sclk_i) begin
    master_q <= master_d;
    open_q <= open_d;
  end

  // slave stage: msb enters first and ends up on top
  always_comb begin
    slave_d = open_q ? {slave_q[6:0], master_q} : slave_q; // [R1] [R2] [R5]
  end

  always_ff @(negedge sclk_i) begin
    slave_q <= slave_d;
  end

  assign word_o = slave_q;

  slave_capture_a: assert property ( // [R2]
    @(posedge sclk_i) !en_i ##1 !en_i |-> word_o[0] == $past(din_i))
    else $error("slave bit 0 does not hold the captured bit");

  // nine open rises in a row: the register has been filled once, so no unknown bits remain
  msb_first_a: assert property ( // [R1]
    @(posedge sclk_i) !en_i [*8] ##1 !en_i |-> word_o[7:1] == $past(word_o[6:0]))
    else $error("word does not shift toward the msb");

  shift_inhibit_a: assert property ( // [R4]
    @(posedge sclk_i) en_i |=> $stable(word_o))
    else $error("word changed while commit enable was high");

endmodule // sgcp_shift

// >>> design/sgcp_sync.sv
// two-flop synchroniser into the system clock domain
module sgcp_sync #(
  parameter int W = 2
) (
  // clock
  input wire logic clk_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // meta_q is read by sync_q only
  always_comb begin
    meta_d = ce_i ? d_i : meta_q;
    sync_d = ce_i ? meta_q : sync_q;
  end

  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign q_o = sync_q;

endmodule // sgcp_sync

// >>> sim/sgcp_host.sv
// behavioural host controller that shifts gain words into the port
module sgcp_host (
  // serial link
  output logic sclk_o,
  output logic data_o,
  output logic en_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_o = 1'b0;
    data_o = 1'b0;
    en_o = 1'b0;
  end

  // clock stands low between words, so the two domains never share a phase
  task automatic send_word(input logic [7:0] w);
    #7.3;
    for (int i = 7; i >= 0; i--) begin
      data_o = w[i];
      #62.5;
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
    // line is no longer held: show the inverse rather than a stale level
    data_o = ~data_o;
  endtask

  task automatic set_en(input logic v);
    en_o = v;
  endtask
endmodule // sgcp_host

// >>> sim/sgcp_port_tb.sv
// self-checking bench for the serial gain control port
`include "sgcp_map.svh"
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end

module sgcp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pwr = 1'b0;
  logic ce = 1'b1;
  int n_upd = 0;
  logic sclk, sdat, gen, amp_on, upd, shift_open;
  logic [2:0] code;
  logic signed [7:0] db;
  logic [7:0] w;
  int num_errors = 0;
  int compares = 0;

  always #2 clk_i = ~clk_i;

  sgcp_host host_u (.sclk_o(sclk), .data_o(sdat), .en_o(gen));

  sgcp_port dut_u (
    .CLK_I(clk_i), .RST_I(rst_i), .CE_I(ce),
    .SCLK_I(sclk), .SERIAL_GAIN_IN_I(sdat), .GAIN_COMMIT_ENABLE_I(gen),
    .POWER_ON_SELECT_I(pwr),
    .AMP_ON_O(amp_on), .GAIN_CODE_O(code), .GAIN_DB_O(db),
    .GAIN_UPDATE_O(upd), .SHIFT_OPEN_O(shift_open)
  );

  function automatic logic [2:0] exp_code(input logic [7:0] v);
    return (v > `SGCP_WORD_MAX) ? `SGCP_CODE_MAX : v[2:0];
  endfunction

  function automatic logic signed [7:0] exp_db(input logic [2:0] c);
    return 8'(`SGCP_DB_MIN + {5'h00, c} * `SGCP_DB_STEP);
  endfunction

  task automatic print_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wait_update();
    int n;
    n = 0;
    while (upd !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 40) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic commit_word(input logic [7:0] v);
    host_u.set_en(1'b0);
    host_u.send_word(v);
    @(negedge clk_i);
    `CHECK("shift_open", 1'b1, shift_open)
    host_u.set_en(1'b1);
    wait_update();
    `CHECK("code", exp_code(v), code)
    `CHECK("db", exp_db(exp_code(v)), db)
    `CHECK("shift_closed", 1'b0, shift_open)
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h1fc0bdbb));
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHECK("amp_off", 1'b0, amp_on)
    pwr = 1'b1;
    repeat (5) @(negedge clk_i);
    `CHECK("amp_on", 1'b1, amp_on)
    `CHECK("code_min", `SGCP_CODE_MIN, code)
    `CHECK("db_min", `SGCP_DB_MIN, db)
    // boundary words first, then random ones with the even-numbered ones inside the step range, and a small word last
    for (int i = 0; i < 20; i++) begin
      case (i)
        0: w = 8'h00;
        1: w = 8'h07;
        2: w = 8'h08;
        3: w = 8'hff;
        19: w = 8'h02;
        default: w = (i % 2 == 0) ? 8'($urandom_range(7, 0)) : 8'($urandom);
      endcase
      commit_word(w);
    end
    // bits offered while enable is high must not enter the register;
    // the last word is small so that its inverse maps to another code
    host_u.send_word(~w);
    @(negedge clk_i);
    host_u.set_en(1'b0);
    repeat (6) @(negedge clk_i);
    `CHECK("frozen", exp_code(w), code)
    host_u.set_en(1'b1);
    wait_update();
    `CHECK("refused", exp_code(w), code)
    pwr = 1'b0;
    repeat (5) @(negedge clk_i);
    `CHECK("amp_down", 1'b0, amp_on)
    // a commit while powered down is lost and never pulses the update
    host_u.set_en(1'b0);
    host_u.send_word(8'h05);
    @(negedge clk_i);
    host_u.set_en(1'b1);
    n_upd = 0;
    for (int k = 0; k < 12; k++) begin
      @(negedge clk_i);
      if (upd === 1'b1) begin
        n_upd++;
      end
    end
    `CHECK("off_update", 0, n_upd)
    `CHECK("off_amp", 1'b0, amp_on)
    pwr = 1'b1;
    repeat (5) @(negedge clk_i);
    `CHECK("amp_up", 1'b1, amp_on)
    `CHECK("code_up", `SGCP_CODE_MIN, code)
    commit_word(8'h03);
    // clock enable low freezes the system side, power select included
    ce = 1'b0;
    pwr = 1'b0;
    repeat (8) @(negedge clk_i);
    `CHECK("ce_frozen", 1'b1, amp_on)
    `CHECK("ce_code", 3'h3, code)
    ce = 1'b1;
    repeat (5) @(negedge clk_i);
    `CHECK("ce_released", 1'b0, amp_on)
    print_verdict();
  end
endmodule // sgcp_port_tb
